// file: dv/lin_far_node.sv
// lin_far_node: remote lin node that drives the receive line.
// assumes bit ticks come from the bench clock domain.
`timescale 1ns/1ps
`default_nettype none
module lin_far_node (
    // clock and bit time
    input  wire logic i_clk,
    input  wire logic i_bit_tick,
    // serial line
    output logic      o_line
);
    initial o_line = 1'b1;
    // ==========================================
    // hold a level for n bit times, then back to idle high
    task automatic hold(input logic lvl, input int n);
        o_line <= lvl;
        repeat (n) @(posedge i_clk iff i_bit_tick);
        o_line <= 1'b1;
    endtask : hold
endmodule : lin_far_node
`default_nettype wire

// file: dv/tb.sv
// tb: self-checking bench for lin_aux with an apb master and a far node.
// assumes zero-wait apb and one bit tick every four clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp=%h got=%h", n, e, g); end end
module tb;
    import lin_aux_pkg::*;
    typedef struct packed {logic [31:0] m; logic [31:0] v;} note_t;
    logic clk, srst, psel, pen, pwr, tick, wl, loopm, rx_source_select, stby, start, stopl, cdone;
    logic r9, dwr, sbrk, txc, rxl, prdy, slverr, rxd, fset, rfset, idl, load, brk, irq, txp, oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic [8:0] word;
    logic [7:0] dbyte;
    logic [3:0] flg;
    logic [1:0] tdiv;
    int fail_count, checks_done, n, seed;
    note_t q[$];
    note_t e;
    lin_aux u_lin_aux (.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(prdy), .o_pslverr(slverr),
        .i_bit_tick(tick), .i_word_length_select(wl), .i_loop_mode_select(loopm),
        .i_rx_source_select(rx_source_select), .i_rx_standby(stby), .i_start_detect(start),
        .i_stop_sample_low(stopl), .i_char_done(cdone), .i_rx_ninth_bit(r9), .i_data_write(dwr),
        .i_data_byte(dbyte), .i_send_break(sbrk), .i_overrun_flag(flg[3]), .i_noise_flag(flg[2]),
        .i_framing_error_flag(flg[1]), .i_parity_error_flag(flg[0]), .o_rx_data(rxd),
        .o_framing_set(fset), .o_rx_full_set(rfset), .o_idle_set(idl), .o_shift_load(load),
        .o_shift_word(word), .o_break_active(brk), .o_irq(irq), .i_rx_pin(rxl), .i_tx_core(txc),
        .o_tx_pin(txp), .o_tx_pin_oe(oe));
    lin_far_node u_lin_far_node (.i_clk(clk), .i_bit_tick(tick), .o_line(rxl));
    // ==========================================
    // clock, bit tick, watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    // ==========================================
    // read watcher: oldest note against returned data
    always @(posedge clk) begin
        if (psel && pen && prdy === 1'b1 && !pwr && q.size() > 0) begin
            e = q.pop_front();
            `CHK("prdata", e.v, prdata & e.m)
            `CHK("pslverr", paddr > CONTROL_OFFSET, slverr)
        end
    end
    // ==========================================
    // apb master
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        if (k >= 20) begin
            fail_count++;
            end_sim();
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        q.push_back({m, v});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic end_sim;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    // ==========================================
    // main sequence
    initial begin
        seed = 32'h34BB6CEB;
        {psel, pen, pwr, tick, wl, loopm, rx_source_select, stby, start, stopl, cdone, r9, dwr, sbrk, txc} = '0;
        {paddr, pwdata, dbyte, flg, tdiv} = '0;
        srst = 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(STATUS_OFFSET, 32'hFFFFFFFF, {24'h0, STATUS_RESET});
        rd(CONTROL_OFFSET, 32'hFFFFFFFF, {24'h0, CONTROL_RESET});
        rd(12'h010, 32'hFFFFFFFF, 32'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, CONTROL_OFFSET, 32'h1 << k);
            flg <= 4'h1 << k;
            @(negedge clk) `CHK("irq_on", 1'b1, irq)
            @(posedge clk) flg <= ~(4'h1 << k);
            @(negedge clk) `CHK("irq_off", 1'b0, irq)
            @(posedge clk) flg <= 4'h0;
        end
        rnd = $random(seed);
        apb(1'b1, CONTROL_OFFSET, rnd);
        rd(CONTROL_OFFSET, 32'hFFFFFFFF, {25'h0, rnd[6:0]});
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, CONTROL_OFFSET, c ? 32'h30 : 32'h10);
            loopm <= 1'b1;
            rx_source_select <= 1'b1;
            txc <= $random(seed);
            @(negedge clk) `CHK("oe", c[0], oe)
            `CHK("tx_inv", ~txc, txp)
        end
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, STATUS_OFFSET, c[1] << LONG_BRK_BIT);
            wl <= c[0];
            sbrk <= 1'b1;
            @(posedge clk) sbrk <= 1'b0;
            n = 0;
            for (int t = 0; t < 200 && (t < 3 || brk); t++) @(posedge clk) n += (brk && tick);
            `CHK("brk_len", (c[1] ? 13 : 10) + c[0], n)
        end
        wl <= 1'b0;
        apb(1'b1, CONTROL_OFFSET, 32'h40);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk) dwr <= 1'b1;
            dbyte <= $random(seed);
            @(posedge clk) dwr <= 1'b0;
            @(negedge clk) `CHK("shift_word", {2'b11, dbyte}, {load, word})
        end
        apb(1'b1, STATUS_OFFSET, 32'h02);
        u_lin_far_node.hold(1'b0, 10);
        rd(STATUS_OFFSET, 32'hC0, 32'h40);
        u_lin_far_node.hold(1'b0, 12);
        rd(STATUS_OFFSET, 32'hC0, 32'hC0);
        apb(1'b1, STATUS_OFFSET, 32'h02);
        rd(STATUS_OFFSET, 32'hC0, 32'hC0);
        apb(1'b1, STATUS_OFFSET, 32'hD3);
        rd(STATUS_OFFSET, 32'hC1, 32'h00);
        u_lin_far_node.hold(1'b0, 1);
        @(negedge clk) `CHK("rx_inv", ~rxl, rxd)
        rd(STATUS_OFFSET, 32'h40, 32'h40);
        r9 <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, STATUS_OFFSET, (c << LONG_DET_BIT) | 32'h04);
            stopl <= 1'b1;
            cdone <= 1'b1;
            @(negedge clk) `CHK("fe_rx_full_flag", {2{~c[0]}}, {fset, rfset})
            @(posedge clk) stopl <= 1'b0;
            cdone <= 1'b0;
        end
        rd(CONTROL_OFFSET, 32'h80, 32'h80);
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, STATUS_OFFSET, 32'h00);
            stby <= c[0];
            start <= 1'b1;
            @(posedge clk) start <= 1'b0;
            rd(STATUS_OFFSET, 32'h01, 32'h01);
            n = 0;
            for (int t = 0; t < 60; t++) @(posedge clk) n += idl;
            `CHK("idle_cnt", c ? 1 - c : 1, n)
            rd(STATUS_OFFSET, 32'h01, 32'h00);
        end
        end_sim();
    end
endmodule : tb
`default_nettype wire

// file: rtl/lin_aux.sv
// lin_aux: APB-mapped status/control registers plus break, edge, idle and break-send logic of a LIN UART.
// assumes the UART core supplies a one-cycle bit tick, receiver events and the raw pin levels, all synchronous.
`timescale 1ns/1ps
`default_nettype none
module lin_aux (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // core configuration and events
    input  wire logic        i_bit_tick,
    input  wire logic        i_word_length_select,
    input  wire logic        i_loop_mode_select,
    input  wire logic        i_rx_source_select,
    input  wire logic        i_rx_standby,
    input  wire logic        i_start_detect,
    input  wire logic        i_stop_sample_low,
    input  wire logic        i_char_done,
    input  wire logic        i_rx_ninth_bit,
    input  wire logic        i_data_write,
    input  wire logic [7:0]  i_data_byte,
    input  wire logic        i_send_break,
    // core error flags
    input  wire logic        i_overrun_flag,
    input  wire logic        i_noise_flag,
    input  wire logic        i_framing_error_flag,
    input  wire logic        i_parity_error_flag,
    // core-side results
    output logic             o_rx_data,
    output logic             o_framing_set,
    output logic             o_rx_full_set,
    output logic             o_idle_set,
    output logic             o_shift_load,
    output logic      [8:0]  o_shift_word,
    output logic             o_break_active,
    output logic             o_irq,
    // pins
    input  wire logic        i_rx_pin,
    input  wire logic        i_tx_core,
    output logic             o_tx_pin,
    output logic             o_tx_pin_oe
);
    import lin_aux_pkg::*;

    // ==========================================
    // state
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] control;
        logic       rx_prev;
        logic [3:0] low_count;
        logic [3:0] high_count;
        logic       brk_armed;
        logic       idle_armed;
        logic       brk_tx;
        logic [3:0] brk_count;
        logic       shift_load;
        logic [8:0] shift_word;
        logic       idle_set;
        logic [31:0] prdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic rx_level;
    logic wr_en;
    logic rd_en;
    logic hit_status;
    logic hit_control;
    logic [3:0] det_limit;
    logic [3:0] idle_limit;
    logic [3:0] brk_limit;
    logic long_det;
    logic active_edge;

    // ==========================================
    // apb decode
    assign hit_status  = (i_paddr == STATUS_OFFSET);
    assign hit_control = (i_paddr == CONTROL_OFFSET);
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && !i_penable && !i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit_status && !hit_control;
    assign o_prdata  = state_reg.prdata;

    // ==========================================
    // pin paths
    assign rx_level = i_rx_pin ^ state_reg.status[RX_INV_BIT]; // R3
    assign o_rx_data = rx_level;
    // active edge is taken on the raw pin so that toggling rx_invert alone raises no edge
    assign active_edge = state_reg.status[RX_INV_BIT] ? (!state_reg.rx_prev && i_rx_pin) // R2
                                                      : (state_reg.rx_prev && !i_rx_pin); // R2
    assign o_tx_pin = (state_reg.brk_tx ? 1'b0 : i_tx_core) ^ state_reg.control[TX_INV_BIT]; // R15
    assign o_tx_pin_oe = !(i_loop_mode_select && i_rx_source_select) || state_reg.control[DIR_BIT]; // R14
    assign long_det = state_reg.status[LONG_DET_BIT];
    assign o_framing_set = i_stop_sample_low && !long_det; // R20 R7 R6
    assign o_rx_full_set = i_char_done && !long_det; // R7
    assign o_idle_set = state_reg.idle_set;
    assign o_shift_load = state_reg.shift_load;
    assign o_shift_word = state_reg.shift_word;
    assign o_break_active = state_reg.brk_tx;
    assign o_irq = (i_overrun_flag && state_reg.control[OVR_IE_BIT]) // R16
                || (i_noise_flag && state_reg.control[NOISE_IE_BIT]) // R17
                || (i_framing_error_flag && state_reg.control[FRAME_IE_BIT]) // R18
                || (i_parity_error_flag && state_reg.control[PARITY_IE_BIT]); // R19

    // ==========================================
    // thresholds
    always_comb begin
        det_limit = long_det ? BRK_DET_LONG : BRK_DET_SHORT; // R8
        idle_limit = IDLE_SHORT;
        brk_limit = state_reg.status[LONG_BRK_BIT] ? BRK_TX_LONG : BRK_TX_SHORT; // R5
        if (i_word_length_select) begin
            det_limit = det_limit + ONE_BIT;
            idle_limit = IDLE_LONG; // R21
            brk_limit = brk_limit + ONE_BIT;
        end
    end

    // ==========================================
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.rx_prev = i_rx_pin;
        state_next.shift_load = 1'b0;
        state_next.idle_set = 1'b0;
        // edge flag: falling pin, or rising pin when inverted
        if (active_edge) begin
            state_next.status[EDGE_FLAG_BIT] = 1'b1; // R2
        end else if (wr_en && hit_status && i_pwdata[EDGE_FLAG_BIT]) begin
            state_next.status[EDGE_FLAG_BIT] = 1'b0; // R22
        end
        // receiver active
        if (i_start_detect) begin
            state_next.status[RX_ACTIVE_BIT] = 1'b1; // R10
            state_next.idle_armed = 1'b1;
        end
        // low and high run counters on bit ticks
        if (rx_level) begin
            state_next.low_count = COUNT_ZERO;
            state_next.brk_armed = 1'b1;
        end
        if (!rx_level) begin
            state_next.high_count = COUNT_ZERO;
        end
        if (i_bit_tick) begin
            if (!rx_level && state_reg.low_count != det_limit) begin
                state_next.low_count = state_reg.low_count + ONE_BIT;
            end
            if (rx_level && state_reg.high_count != idle_limit) begin
                state_next.high_count = state_reg.high_count + ONE_BIT;
            end
        end
        // idle time is counted afresh from each start bit
        if (i_start_detect) begin
            state_next.high_count = COUNT_ZERO; // R21
        end
        // break detect
        if (state_reg.low_count == det_limit && state_reg.brk_armed && long_det) begin
            state_next.status[BRK_FLAG_BIT] = 1'b1; // R1
            state_next.brk_armed = 1'b0;
        end else if (wr_en && hit_status && i_pwdata[BRK_FLAG_BIT]) begin
            state_next.status[BRK_FLAG_BIT] = 1'b0; // R22
        end
        // idle line: clears activity, flags idle once
        if (state_reg.high_count == idle_limit && state_reg.idle_armed && !i_start_detect) begin
            state_next.status[RX_ACTIVE_BIT] = 1'b0; // R10
            state_next.idle_armed = 1'b0;
            state_next.idle_set = !i_rx_standby || state_reg.status[WAKE_IDLE_BIT]; // R4 R21
        end
        // control fields written by software
        if (wr_en && hit_status) begin
            state_next.status[RX_INV_BIT] = i_pwdata[RX_INV_BIT];
            state_next.status[WAKE_IDLE_BIT] = i_pwdata[WAKE_IDLE_BIT];
            state_next.status[LONG_BRK_BIT] = i_pwdata[LONG_BRK_BIT];
            state_next.status[LONG_DET_BIT] = i_pwdata[LONG_DET_BIT];
        end
        if (wr_en && hit_control) begin
            state_next.control[6:0] = i_pwdata[6:0]; // R13
        end
        state_next.control[RX_NINTH_BIT] = i_char_done ? i_rx_ninth_bit : state_reg.control[RX_NINTH_BIT];
        // ninth bit goes to the shifter with the data byte
        if (i_data_write) begin
            state_next.shift_load = 1'b1;
            state_next.shift_word = {state_reg.control[TX_NINTH_BIT], i_data_byte}; // R12
        end
        // break transmit
        if (!state_reg.brk_tx && i_send_break) begin
            state_next.brk_tx = 1'b1;
            state_next.brk_count = COUNT_ZERO;
        end else if (state_reg.brk_tx && i_bit_tick) begin
            if (state_reg.brk_count + ONE_BIT == brk_limit) begin
                state_next.brk_tx = 1'b0; // R5
            end
            state_next.brk_count = state_reg.brk_count + ONE_BIT;
        end
        // read data
        if (rd_en) begin
            state_next.prdata = hit_status ? {24'h000000, state_reg.status}
                              : hit_control ? {24'h000000, state_reg.control} : READ_ZERO;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= '0;
            state_reg.status <= STATUS_RESET;
            state_reg.control <= CONTROL_RESET;
            state_reg.rx_prev <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================
    // checks
    edge_flag_a: assert property (@(posedge i_clk) disable iff (i_srst) // R2
        active_edge |=> state_reg.status[EDGE_FLAG_BIT])
        else $error("edge flag missed");
    brk_flag_a: assert property (@(posedge i_clk) disable iff (i_srst) // R1
        state_reg.low_count == det_limit && state_reg.brk_armed && long_det |=> state_reg.status[BRK_FLAG_BIT])
        else $error("break flag missed");
    brk_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // R22
        state_reg.status[BRK_FLAG_BIT] && !(wr_en && hit_status && i_pwdata[BRK_FLAG_BIT])
        |=> state_reg.status[BRK_FLAG_BIT])
        else $error("break flag lost");
    irq_nf_a: assert property (@(posedge i_clk) disable iff (i_srst) // R17
        i_noise_flag && state_reg.control[NOISE_IE_BIT] |-> o_irq)
        else $error("noise irq missing");
    irq_fe_a: assert property (@(posedge i_clk) disable iff (i_srst) // R18
        i_framing_error_flag && state_reg.control[FRAME_IE_BIT] |-> o_irq)
        else $error("framing irq missing");
    irq_pf_a: assert property (@(posedge i_clk) disable iff (i_srst) // R19
        i_parity_error_flag && state_reg.control[PARITY_IE_BIT] |-> o_irq)
        else $error("parity irq missing");
    ninth_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // R13
        !(wr_en && hit_control) |=> $stable(state_reg.control[TX_NINTH_BIT]))
        else $error("tx ninth bit changed");
    idle_block_a: assert property (@(posedge i_clk) disable iff (i_srst) // R4
        i_rx_standby && !state_reg.status[WAKE_IDLE_BIT] |=> !o_idle_set)
        else $error("idle flagged in standby");
    brk_len_a: assert property (@(posedge i_clk) disable iff (i_srst) // R5
        state_reg.brk_tx |-> state_reg.brk_count < brk_limit)
        else $error("break too long");
    oe_drive_a: assert property (@(posedge i_clk) disable iff (i_srst) // R14
        !(i_loop_mode_select && i_rx_source_select) |-> o_tx_pin_oe)
        else $error("tx pin not driven");
    edge_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // R22
        state_reg.status[EDGE_FLAG_BIT] && !(wr_en && hit_status && i_pwdata[EDGE_FLAG_BIT])
        |=> state_reg.status[EDGE_FLAG_BIT])
        else $error("edge flag lost");
    frame_block_a: assert property (@(posedge i_clk) disable iff (i_srst) // R7
        long_det |-> !o_framing_set && !o_rx_full_set)
        else $error("framing not blocked");
    irq_or_a: assert property (@(posedge i_clk) disable iff (i_srst) // R16
        i_overrun_flag && state_reg.control[OVR_IE_BIT] |-> o_irq)
        else $error("overrun irq missing");
    tx_inv_a: assert property (@(posedge i_clk) disable iff (i_srst) // R15
        state_reg.brk_tx |-> o_tx_pin == state_reg.control[TX_INV_BIT])
        else $error("break level wrong");
    ninth_a: assert property (@(posedge i_clk) disable iff (i_srst) // R12
        i_data_write |=> o_shift_load && o_shift_word[8] == $past(state_reg.control[TX_NINTH_BIT]))
        else $error("ninth bit not loaded");
    dir_a: assert property (@(posedge i_clk) disable iff (i_srst) // R14
        i_loop_mode_select && i_rx_source_select && !state_reg.control[DIR_BIT] |-> !o_tx_pin_oe)
        else $error("single wire direction wrong");
    active_a: assert property (@(posedge i_clk) disable iff (i_srst) // R10
        i_start_detect |=> state_reg.status[RX_ACTIVE_BIT])
        else $error("active flag not set");
endmodule : lin_aux
`default_nettype wire

// file: rtl/lin_aux_pkg.sv
// lin_aux_pkg: register map, field positions and constants of the LIN auxiliary status/control block.
// assumes one 10 MHz bus clock and a surrounding UART core that supplies bit-time ticks.
//
// What this block does, and what its users should do
// R1: break seen while enabled sets break flag
// R2: active rx edge sets edge flag
// R3: rx_invert flips every received element
// R4: standby idle sets idle only if selected
// R5: tx break 10/13 bits, plus one if 9-bit
// R6: framing check ignores long_break_select
// R7: long break detect blocks framing and full flags
// R8: break threshold 10/11 bits, plus one if 9-bit
// R9: internal-oscillator nodes should enable long detect
// R10: receiver active set on start, cleared on idle
// R11: software reads rx ninth bit before data
// R12: tx ninth bit loads with data into shifter
// R13: tx ninth bit holds between writes
// R14: single-wire direction sets tx pin direction
// R15: tx_invert flips every transmitted element
// R16: overrun with enable raises interrupt
// R17: noise with enable raises interrupt
// R18: framing error with enable raises interrupt
// R19: parity error with enable raises interrupt
// R20: stop bit low sets framing with full flag
// R21: idle flag once after full idle character
// R22: zero writes change no flag; a one written to status clears the flag
package lin_aux_pkg;
    // ==========================================
    // register offsets
    localparam logic [11:0] STATUS_OFFSET  = 12'h000;
    localparam logic [11:0] CONTROL_OFFSET = 12'h004;
    // ==========================================
    // status register fields
    localparam int BRK_FLAG_BIT   = 7;
    localparam int EDGE_FLAG_BIT  = 6;
    localparam int RX_INV_BIT     = 4;
    localparam int WAKE_IDLE_BIT  = 3;
    localparam int LONG_BRK_BIT   = 2;
    localparam int LONG_DET_BIT   = 1;
    localparam int RX_ACTIVE_BIT  = 0;
    // ==========================================
    // control register fields
    localparam int RX_NINTH_BIT   = 7;
    localparam int TX_NINTH_BIT   = 6;
    localparam int DIR_BIT        = 5;
    localparam int TX_INV_BIT     = 4;
    localparam int OVR_IE_BIT     = 3;
    localparam int NOISE_IE_BIT   = 2;
    localparam int FRAME_IE_BIT   = 1;
    localparam int PARITY_IE_BIT  = 0;
    // ==========================================
    // reset values and bit-time counts
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [3:0] BRK_TX_SHORT  = 4'hA;
    localparam logic [3:0] BRK_TX_LONG   = 4'hD;
    localparam logic [3:0] BRK_DET_SHORT = 4'hA;
    localparam logic [3:0] BRK_DET_LONG  = 4'hB;
    localparam logic [3:0] IDLE_SHORT    = 4'hA;
    localparam logic [3:0] IDLE_LONG     = 4'hB;
    localparam logic [3:0] ONE_BIT       = 4'h1;
    localparam logic [3:0] COUNT_ZERO    = 4'h0;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
endpackage : lin_aux_pkg
